/* File: pas_pkg.sv */
// pas_pkg: constants and types for the presignal alarm sequencer.
// assumes a 40 MHz system clock and one-second based timing.
`default_nettype none
package pas_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CLK_HZ            = 40000000;
	localparam int unsigned TICK_CYCLES       = CLK_HZ;
	localparam logic [25:0] TICK_LAST         = 26'(TICK_CYCLES - 1);
	localparam logic [7:0]  DELAY_MIN_S       = 8'h3c;
	localparam logic [7:0]  DELAY_MAX_S       = 8'hb4;
	localparam logic [7:0]  ACK_WINDOW_S      = 8'h0f;
	localparam logic [1:0]  ALT_PERIOD_S      = 2'h3;

	// ****************************************************************
	// display fields
	// ****************************************************************
	localparam int unsigned TYPE_W            = 8;
	localparam int unsigned ADDR_W            = 10;

	// ****************************************************************
	// sequencer states
	// ****************************************************************
	typedef enum logic [2:0] {
		PAS_IDLE,
		PAS_ACK_WAIT,
		PAS_DELAY,
		PAS_ACTIVE,
		PAS_INHIBITED
	} pas_state_t;

endpackage : pas_pkg
`default_nettype wire

/* File: pas_sequencer.sv */
// pas_sequencer: presignal delay and positive alarm sequence controller.
// assumes key and alarm inputs are clean one-cycle pulses synchronous to clock.
//
// What this block does
// - first delayed-zone alarm holds delayed outputs off for 60..180 s.
// - with sequence option, no acknowledge in 15 s activates every output.
// - acknowledge inside 15 s window restarts the full programmed delay.
// - second alarm during delay cancels it and activates every output.
// - sequence-inhibit monitor on alarm forces delayed zone off, aborts delay.
// - alarm flashes fire led, pulses sounder, latches until clear and reset.
// - acknowledge silences sounder outside drill and makes fire led steady.
// - system reset key during delay aborts the delay.
// - drill activates delayed outputs, pulses sounder, steady led, 3 s alternation.
// - delay expiring without operator action activates delayed-zone outputs.
// - alarm relay, reversal and box outputs delayed only with sequence option.
// - each alarm reports device type and loop address for display.
`timescale 1ns/1ps
`default_nettype none
module pas_sequencer (
	input  wire logic                       clock,
	input  wire logic                       rst,
	input  wire logic                       alarm_pulse,
	input  wire logic                       alarm_in_delayed_zone,
	input  wire logic [pas_pkg::TYPE_W-1:0] alarm_type,
	input  wire logic [pas_pkg::ADDR_W-1:0] alarm_address,
	input  wire logic                       alarm_present,
	input  wire logic                       inhibit_present,
	input  wire logic                       positive_alarm_sequence,
	input  wire logic [7:0]                 presignal_delay_s,
	input  wire logic                       ack_key,
	input  wire logic                       reset_key,
	input  wire logic                       drill_key,
	output logic                            delayed_zone_active,
	output logic                            general_outputs_active,
	output logic                            system_alarm_relay,
	output logic                            reversal_output,
	output logic                            box_output,
	output logic                            fire_led,
	output logic                            sounder,
	output logic                            show_evacuate,
	output logic [pas_pkg::TYPE_W-1:0]      disp_type,
	output logic [pas_pkg::ADDR_W-1:0]      disp_address,
	output logic                            disp_valid
);

	// ****************************************************************
	// one-second tick
	// ****************************************************************
	logic [25:0] tick_cnt_ff;
	logic        tick;
	assign tick = (tick_cnt_ff == pas_pkg::TICK_LAST);

	always_ff @(posedge clock) begin
		if (rst || tick)
			tick_cnt_ff <= '0;
		else
			tick_cnt_ff <= tick_cnt_ff + 26'h1;
	end

	// half-second phase drives the flash and pulse cadence
	logic half_phase;
	assign half_phase = (tick_cnt_ff >= 26'(pas_pkg::TICK_CYCLES / 2));

	// ****************************************************************
	// programmed delay, clamped to the legal range
	// ****************************************************************
	logic [7:0] delay_s;
	always_comb begin
		if (presignal_delay_s < pas_pkg::DELAY_MIN_S)
			delay_s = pas_pkg::DELAY_MIN_S;
		else if (presignal_delay_s > pas_pkg::DELAY_MAX_S)
			delay_s = pas_pkg::DELAY_MAX_S;
		else
			delay_s = presignal_delay_s;
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	pas_pkg::pas_state_t state_ff;
	pas_pkg::pas_state_t nxt_state;
	logic [7:0]          secs_ff;
	logic [7:0]          nxt_secs;
	logic                latched_ff;
	logic                acked_ff;
	logic                drill_ff;
	logic                pas_run_ff;
	logic                release_ok;

	// the latch only drops once the alarm is cleared and reset is pressed
	assign release_ok = reset_key && !alarm_present;

	always_comb begin
		nxt_state = state_ff;
		nxt_secs  = secs_ff;
		case (state_ff)
			pas_pkg::PAS_IDLE: begin
				if (alarm_pulse && inhibit_present) begin
					nxt_state = pas_pkg::PAS_INHIBITED;
				end else if (alarm_pulse && alarm_in_delayed_zone) begin
					nxt_secs  = '0;
					nxt_state = positive_alarm_sequence ? pas_pkg::PAS_ACK_WAIT
					                                    : pas_pkg::PAS_DELAY;
				end else if (alarm_pulse || drill_key) begin
					nxt_state = pas_pkg::PAS_ACTIVE;
				end
			end
			pas_pkg::PAS_ACK_WAIT: begin
				if (alarm_pulse && inhibit_present) begin
					nxt_state = pas_pkg::PAS_INHIBITED;
				end else if (alarm_pulse || drill_key) begin
					nxt_state = pas_pkg::PAS_ACTIVE;
				end else if (reset_key) begin
					nxt_state = pas_pkg::PAS_INHIBITED;
				end else if (ack_key) begin
					nxt_secs  = '0;
					nxt_state = pas_pkg::PAS_DELAY;
				end else if (tick) begin
					nxt_secs = secs_ff + 8'h1;
					if (nxt_secs >= pas_pkg::ACK_WINDOW_S)
						nxt_state = pas_pkg::PAS_ACTIVE;
				end
			end
			pas_pkg::PAS_DELAY: begin
				if (alarm_pulse && inhibit_present) begin
					nxt_state = pas_pkg::PAS_INHIBITED;
				end else if (alarm_pulse || drill_key) begin
					nxt_state = pas_pkg::PAS_ACTIVE;
				end else if (reset_key) begin
					nxt_state = pas_pkg::PAS_INHIBITED;
				end else if (tick) begin
					nxt_secs = secs_ff + 8'h1;
					if (nxt_secs >= delay_s)
						nxt_state = pas_pkg::PAS_ACTIVE;
				end
			end
			pas_pkg::PAS_ACTIVE, pas_pkg::PAS_INHIBITED: begin
				// an inhibited alarm forces the zone off even once outputs run
				if (alarm_pulse && inhibit_present)
					nxt_state = pas_pkg::PAS_INHIBITED;
				else if (drill_key)
					nxt_state = pas_pkg::PAS_ACTIVE;
			end
			default: nxt_state = pas_pkg::PAS_IDLE;
		endcase
		if (latched_ff && release_ok)
			nxt_state = pas_pkg::PAS_IDLE;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_ff <= pas_pkg::PAS_IDLE;
			secs_ff  <= '0;
		end else begin
			state_ff <= nxt_state;
			secs_ff  <= (nxt_state == pas_pkg::PAS_IDLE) ? 8'h0 : nxt_secs;
		end
	end

	// remembers whether the running sequence uses the option, for the general outputs and the three outputs
	always_ff @(posedge clock) begin
		if (rst)
			pas_run_ff <= 1'b0;
		else if (state_ff == pas_pkg::PAS_IDLE && alarm_pulse)
			pas_run_ff <= positive_alarm_sequence && alarm_in_delayed_zone;
	end

	// ****************************************************************
	// alarm latch, acknowledge and drill
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (rst) begin
			latched_ff <= 1'b0;
		end else if (alarm_pulse || drill_key) begin
			latched_ff <= 1'b1;
		end else if (release_ok) begin
			latched_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			acked_ff <= 1'b0;
		end else if (ack_key && latched_ff) begin
			acked_ff <= 1'b1;
		end else if (alarm_pulse) begin
			acked_ff <= 1'b0;
		end else if (latched_ff && release_ok) begin
			acked_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			drill_ff <= 1'b0;
		else if (drill_key)
			drill_ff <= 1'b1;
		else if (latched_ff && release_ok)
			drill_ff <= 1'b0;
	end

	// ****************************************************************
	// screen alternation
	// ****************************************************************
	logic [1:0] alt_cnt_ff;
	logic       evac_ff;
	always_ff @(posedge clock) begin
		if (rst || !drill_ff) begin
			alt_cnt_ff <= '0;
			evac_ff    <= 1'b0;
		end else if (tick) begin
			if (alt_cnt_ff == pas_pkg::ALT_PERIOD_S - 2'h1) begin
				alt_cnt_ff <= '0;
				evac_ff    <= !evac_ff;
			end else begin
				alt_cnt_ff <= alt_cnt_ff + 2'h1;
			end
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	logic delayed_on;
	logic general_on;
	logic three_on;
	logic pending;
	assign pending    = (state_ff == pas_pkg::PAS_ACK_WAIT) || (state_ff == pas_pkg::PAS_DELAY);
	assign delayed_on = (state_ff == pas_pkg::PAS_ACTIVE);
	assign general_on = latched_ff && (state_ff != pas_pkg::PAS_ACK_WAIT || !positive_alarm_sequence);
	assign three_on   = latched_ff && !(pending && pas_run_ff);

	always_ff @(posedge clock) begin
		if (rst) begin
			delayed_zone_active    <= 1'b0;
			general_outputs_active <= 1'b0;
			system_alarm_relay     <= 1'b0;
			reversal_output        <= 1'b0;
			box_output             <= 1'b0;
			fire_led               <= 1'b0;
			sounder                <= 1'b0;
			show_evacuate          <= 1'b0;
		end else begin
			delayed_zone_active    <= delayed_on;
			general_outputs_active <= general_on && !(pending && pas_run_ff);
			system_alarm_relay     <= three_on;
			reversal_output        <= three_on;
			box_output             <= three_on;
			fire_led               <= latched_ff && (acked_ff || drill_ff || !half_phase);
			sounder                <= latched_ff && (drill_ff || !acked_ff) && !half_phase;
			show_evacuate          <= evac_ff;
		end
	end

	// display capture on every alarm
	always_ff @(posedge clock) begin
		if (rst) begin
			disp_type    <= '0;
			disp_address <= '0;
			disp_valid   <= 1'b0;
		end else if (alarm_pulse) begin
			disp_type    <= alarm_type;
			disp_address <= alarm_address;
			disp_valid   <= 1'b1;
		end else if (latched_ff && release_ok) begin
			disp_valid   <= 1'b0;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_pas_start;
		state_ff == pas_pkg::PAS_IDLE && alarm_pulse && alarm_in_delayed_zone
		&& positive_alarm_sequence && !inhibit_present && !drill_key && !reset_key;
	endsequence

	delay_holds_a: assert property (@(posedge clock) disable iff (rst)
		state_ff == pas_pkg::PAS_DELAY |=> !delayed_zone_active)
		else $error("delayed zone active during delay");
	ack_wait_enter_a: assert property (@(posedge clock) disable iff (rst)
		s_pas_start |=> state_ff == pas_pkg::PAS_ACK_WAIT)
		else $error("sequence did not open ack window");
	ack_timeout_a: assert property (@(posedge clock) disable iff (rst)
		state_ff == pas_pkg::PAS_ACK_WAIT && tick && secs_ff == pas_pkg::ACK_WINDOW_S - 8'h1
		&& !alarm_pulse && !drill_key && !reset_key && !ack_key && !release_ok
		|=> state_ff == pas_pkg::PAS_ACTIVE ##1 delayed_zone_active && general_outputs_active)
		else $error("ack window expiry did not activate");
	delay_expire_a: assert property (@(posedge clock) disable iff (rst)
		state_ff == pas_pkg::PAS_DELAY && tick && secs_ff == delay_s - 8'h1
		&& !alarm_pulse && !drill_key && !reset_key && !release_ok
		|=> state_ff == pas_pkg::PAS_ACTIVE ##1 delayed_zone_active)
		else $error("delay expiry did not activate");
	ack_extend_a: assert property (@(posedge clock) disable iff (rst)
		state_ff == pas_pkg::PAS_ACK_WAIT && ack_key && !alarm_pulse && !drill_key
		&& !reset_key |=> state_ff == pas_pkg::PAS_DELAY && secs_ff == 8'h0)
		else $error("ack did not restart delay");
	second_alarm_a: assert property (@(posedge clock) disable iff (rst)
		pending && alarm_pulse && !inhibit_present && !release_ok
		|=> state_ff == pas_pkg::PAS_ACTIVE ##1 delayed_zone_active)
		else $error("second alarm did not activate");
	inhibit_abort_a: assert property (@(posedge clock) disable iff (rst)
		alarm_pulse && inhibit_present && !drill_key && !release_ok
		|=> ##1 !delayed_zone_active)
		else $error("inhibit did not hold zone off");
	latch_hold_a: assert property (@(posedge clock) disable iff (rst)
		latched_ff && !reset_key |=> latched_ff)
		else $error("alarm latch dropped without reset");
	ack_silence_a: assert property (@(posedge clock) disable iff (rst)
		acked_ff && !drill_ff |=> !sounder)
		else $error("sounder not silenced");
	reset_abort_a: assert property (@(posedge clock) disable iff (rst)
		pending && reset_key && !alarm_pulse && !drill_key && !release_ok
		|=> state_ff == pas_pkg::PAS_INHIBITED)
		else $error("reset key did not abort delay");
	drill_on_a: assert property (@(posedge clock) disable iff (rst)
		drill_key && !release_ok |=> ##1 delayed_zone_active && fire_led)
		else $error("drill did not activate");
	three_delay_a: assert property (@(posedge clock) disable iff (rst)
		latched_ff && !pas_run_ff |=> system_alarm_relay)
		else $error("relay delayed without option");
	disp_cap_a: assert property (@(posedge clock) disable iff (rst)
		alarm_pulse |=> disp_address == $past(alarm_address) && disp_valid)
		else $error("alarm address not captured");
	tick_reset_a: assert property (@(posedge clock)
		rst |=> tick_cnt_ff == 26'h0 && secs_ff == 8'h0)
		else $error("timers not cleared by reset");

endmodule : pas_sequencer
`default_nettype wire

/* File: pas_field.sv */
// pas_field: behavioural model of the operator keys and initiating devices.
// assumes the bench calls its tasks; every input changes at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module pas_field (
	input  wire logic                       clock,
	output logic                            alarm_pulse,
	output logic                            alarm_in_delayed_zone,
	output logic [pas_pkg::TYPE_W-1:0]      alarm_type,
	output logic [pas_pkg::ADDR_W-1:0]      alarm_address,
	output logic                            alarm_present,
	output logic                            inhibit_present,
	output logic                            positive_alarm_sequence,
	output logic [7:0]                      presignal_delay_s,
	output logic                            ack_key,
	output logic                            reset_key,
	output logic                            drill_key
);
	initial begin
		{alarm_pulse, alarm_in_delayed_zone, alarm_type, alarm_address} = '0;
		{alarm_present, inhibit_present, positive_alarm_sequence} = '0;
		{ack_key, reset_key, drill_key} = '0;
		presignal_delay_s = 8'h3c;
	end
	// ****************************************************************
	// events
	// ****************************************************************
	task automatic alarm(input logic zone, input logic [7:0] typ, input logic [9:0] adr);
		@(negedge clock);
		alarm_pulse = 1'b1;
		alarm_in_delayed_zone = zone;
		alarm_type = typ;
		alarm_address = adr;
		alarm_present = 1'b1;
		@(negedge clock);
		alarm_pulse = 1'b0;
		// qualifiers are stale now: show the inverse, not the old value
		alarm_in_delayed_zone = ~zone;
		alarm_type = ~typ;
		alarm_address = ~adr;
	endtask : alarm
	task automatic key(input int k);
		@(negedge clock);
		{ack_key, reset_key, drill_key} = 3'h4 >> k;
		@(negedge clock);
		{ack_key, reset_key, drill_key} = 3'h0;
	endtask : key
	task automatic levels(input logic opt, input logic inh, input logic pres, input logic [7:0] d);
		@(negedge clock);
		positive_alarm_sequence = opt;
		inhibit_present = inh;
		alarm_present = pres;
		presignal_delay_s = d;
	endtask : levels
endmodule : pas_field
`default_nettype wire

/* File: test_presignal_alarm_sequencer.sv */
// test_presignal_alarm_sequencer: scoreboard bench for the alarm sequencer.
// assumes the run stays inside the first half second, so flashing outputs read high.
`timescale 1ns/1ps
`default_nettype none
module test_presignal_alarm_sequencer;
	typedef struct packed {logic [26:0] e; logic [26:0] m;} pas_note_t;
	logic clock = 1'b0, rst = 1'b1, chk = 1'b0;
	logic al, zn, pres, inh, opt, ak, rk, dk;
	logic [7:0] typ, dly;
	logic [9:0] adr;
	wire [7:0] outs;
	logic [pas_pkg::TYPE_W-1:0] d_typ;
	logic [pas_pkg::ADDR_W-1:0] d_adr;
	logic d_val;
	logic [31:0] rs = 32'h1c6c;
	int n_fail = 0, n_tests = 0;
	pas_note_t notes[$];
	always #12.5 clock = ~clock;
	pas_field u_field (.clock(clock), .alarm_pulse(al), .alarm_in_delayed_zone(zn),
		.alarm_type(typ), .alarm_address(adr), .alarm_present(pres),
		.inhibit_present(inh), .positive_alarm_sequence(opt), .presignal_delay_s(dly),
		.ack_key(ak), .reset_key(rk), .drill_key(dk));
	pas_sequencer u_dut (.clock(clock), .rst(rst), .alarm_pulse(al),
		.alarm_in_delayed_zone(zn), .alarm_type(typ), .alarm_address(adr),
		.alarm_present(pres), .inhibit_present(inh), .positive_alarm_sequence(opt),
		.presignal_delay_s(dly), .ack_key(ak), .reset_key(rk), .drill_key(dk),
		.delayed_zone_active(outs[7]), .general_outputs_active(outs[6]),
		.system_alarm_relay(outs[5]), .reversal_output(outs[4]), .box_output(outs[3]),
		.fire_led(outs[2]), .sounder(outs[1]), .show_evacuate(outs[0]),
		.disp_type(d_typ), .disp_address(d_adr), .disp_valid(d_val));
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	task automatic check(input logic [26:0] seen, input logic [26:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED outputs expected %h seen %h", exp, seen);
		end
	endtask : check
	// outputs settle two cycles after the event; three leaves margin
	task automatic expect_out(input logic [7:0] o, input logic [7:0] om, input logic [18:0] dsp,
		input logic dm);
		repeat (3) @(negedge clock);
		notes.push_back('{{dsp, o}, {{19{dm}}, om}});
		chk = 1'b1;
		@(negedge clock);
		chk = 1'b0;
	endtask : expect_out
	task automatic release_all();
		u_field.levels(opt, 1'b0, 1'b0, dly);
		u_field.key(1);
		expect_out(8'h00, 8'hff, 19'h0, 1'b0);
	endtask : release_all
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up
	// ****************************************************************
	// monitor: oldest note against what the outputs show
	// ****************************************************************
	always @(posedge clock) begin
		pas_note_t n;
		if (chk && notes.size() > 0) begin
			n = notes.pop_front();
			check({d_val, d_typ, d_adr, outs} & n.m, n.e & n.m);
		end
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		wrap_up();
	end
	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		logic [7:0] t;
		logic [9:0] a;
		repeat (4) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		expect_out(8'h00, 8'hff, 19'h0, 1'b1);
		rs = xs(rs);
		t = rs[7:0];
		a = rs[17:8];
		u_field.levels(1'b1, 1'b0, 1'b0, 8'h3c + 8'(rs[31:24] % 121));
		u_field.alarm(1'b1, t, a);
		expect_out(8'h06, 8'hff, {1'b1, t, a}, 1'b1);
		u_field.key(0);
		expect_out(8'h04, 8'hbf, 19'h0, 1'b0);
		rs = xs(rs);
		u_field.alarm(1'b1, rs[7:0], rs[17:8]);
		expect_out(8'hfc, 8'hfc, {1'b1, rs[7:0], rs[17:8]}, 1'b1);
		release_all();
		// without the sequence option the three remote outputs go at once
		u_field.levels(1'b0, 1'b0, 1'b0, 8'hb4);
		u_field.alarm(1'b1, t, a);
		expect_out(8'h7e, 8'hff, 19'h0, 1'b0);
		u_field.key(2);
		expect_out(8'h86, 8'h87, 19'h0, 1'b0);
		release_all();
		u_field.alarm(1'b1, t, a);
		u_field.key(1);
		expect_out(8'h04, 8'h84, 19'h0, 1'b0);
		u_field.key(2);
		expect_out(8'h80, 8'h80, 19'h0, 1'b0);
		release_all();
		u_field.levels(1'b1, 1'b1, 1'b0, 8'h3c);
		u_field.alarm(1'b1, t, a);
		expect_out(8'h04, 8'h84, 19'h0, 1'b0);
		u_field.key(2);
		expect_out(8'h84, 8'h84, 19'h0, 1'b0);
		// a further alarm with the inhibit monitor present drops the running zone
		u_field.alarm(1'b1, t, a);
		expect_out(8'h04, 8'h84, 19'h0, 1'b0);
		release_all();
		u_field.alarm(1'b0, t, a);
		expect_out(8'h78, 8'h78, 19'h0, 1'b0);
		@(negedge clock);
		rst = 1'b1;
		repeat (4) @(negedge clock);
		rst = 1'b0;
		expect_out(8'h00, 8'hff, 19'h0, 1'b1);
		release_all();
		wrap_up();
	end
endmodule : test_presignal_alarm_sequencer
`default_nettype wire
